// ### hdl/tmr2_timer.sv
/*
 * 16-bit timer/counter with auto-reload, capture and baud-rate modes,
 * reached over a classic Wishbone slave with 32-bit data.
 * Assumes count and trigger pins and the other timer's overflow are
 * synchronous-capable inputs; one clock, synchronous active-high reset.
 */
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tmr2_regs.svh"

module tmr2_timer
  import tmr2_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // External pins
  input wire logic count_input_pin_i,
  input wire logic ext_trigger_pin_i,
  // Serial port timebase
  input wire logic timer1_overflow_i,
  output logic rx_baud_tick_o,
  output logic tx_baud_tick_o,
  // Interrupt
  output logic irq_o
);

  // ****************************************
  // Declarations
  // ****************************************
  logic ack_q; // Bus answer
  logic [31:0] rdat_q; // Registered read data
  logic [7:0] ctrl_q; // Control bits
  logic tick_speed_select_q; // Fast timer ticks
  logic [7:0] cap_lo_q, cap_hi_q; // Capture/reload bytes
  logic [15:0] count_q; // Counter
  logic [3:0] presc_q; // Clock prescaler
  logic [1:0] irq_stat_q, irq_en_q; // Interrupt status and enable
  logic cnt_s1_q, cnt_s2_q, cnt_prev_q; // Count pin sync
  logic trg_s1_q, trg_s2_q, trg_prev_q; // Trigger pin sync
  logic [7:0] idx; // Register index
  logic wr_en; // Write takes effect
  logic wr_ctrl, wr_cap_lo, wr_cap_hi, wr_cnt_lo, wr_cnt_hi; // Write strobes
  logic baud_mode; // Either clock select set
  tmr2_mode_type mode; // Decoded mode
  logic [3:0] div_sel; // Active prescale divide
  logic presc_tick; // Prescaler wrap
  logic cnt_fall, trg_fall; // Synchronised falling edges
  logic inc; // Counter advances
  logic ovf; // Counter wraps this cycle
  logic trg_event; // Enabled trigger edge
  logic capture; // Capture fires
  logic reload; // Counter reloads
  logic [15:0] reload_val; // Reload value

  // ****************************************
  // Bus decode
  // ****************************************
  assign idx = wb_adr_i[9:2];
  // Writes land on the acked edge, only with the low lane selected
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
  assign wr_ctrl = wr_en && (idx == `TMR2_IDX_CONTROL);
  assign wr_cap_lo = wr_en && (idx == `TMR2_IDX_CAP_LO);
  assign wr_cap_hi = wr_en && (idx == `TMR2_IDX_CAP_HI);
  assign wr_cnt_lo = wr_en && (idx == `TMR2_IDX_CNT_LO);
  assign wr_cnt_hi = wr_en && (idx == `TMR2_IDX_CNT_HI);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Ack one cycle after the request, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end

  // Read data sampled when the request is taken; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
      unique case (idx)
        `TMR2_IDX_CONTROL: rdat_q <= {24'h00_0000, ctrl_q};
        `TMR2_IDX_CAP_LO: rdat_q <= {24'h00_0000, cap_lo_q};
        `TMR2_IDX_CAP_HI: rdat_q <= {24'h00_0000, cap_hi_q};
        `TMR2_IDX_CNT_LO: rdat_q <= {24'h00_0000, count_q[7:0]};
        `TMR2_IDX_CNT_HI: rdat_q <= {24'h00_0000, count_q[15:8]};
        `TMR2_IDX_CLK_CTRL: rdat_q <= {24'h00_0000, 2'h0, tick_speed_select_q, 5'h00};
        `TMR2_IDX_IRQ_STATUS: rdat_q <= {30'h0000_0000, irq_stat_q};
        `TMR2_IDX_IRQ_ENABLE: rdat_q <= {30'h0000_0000, irq_en_q};
        default: rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  // Third stage holds the previous sample; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_s1_q <= 1'b1;
      cnt_s2_q <= 1'b1;
      cnt_prev_q <= 1'b1;
      trg_s1_q <= 1'b1;
      trg_s2_q <= 1'b1;
      trg_prev_q <= 1'b1;
    end else begin
      cnt_s1_q <= count_input_pin_i;
      cnt_s2_q <= cnt_s1_q;
      cnt_prev_q <= cnt_s2_q;
      trg_s1_q <= ext_trigger_pin_i;
      trg_s2_q <= trg_s1_q;
      trg_prev_q <= trg_s2_q;
    end
  end
  assign cnt_fall = cnt_prev_q && !cnt_s2_q;
  assign trg_fall = trg_prev_q && !trg_s2_q;

  // ****************************************
  // Mode and tick selection
  // ****************************************
  assign baud_mode = ctrl_q[`TMR2_BIT_RX_SEL] || ctrl_q[`TMR2_BIT_TX_SEL];
  always_comb begin
    if (baud_mode) begin
      mode = TMR2_BAUD;
    end else if (ctrl_q[`TMR2_BIT_CAP_SEL]) begin
      mode = TMR2_CAPTURE;
    end else begin
      mode = TMR2_RELOAD;
    end
  end

  // Baud mode divides by two regardless of source select
  always_comb begin
    if (baud_mode) begin
      div_sel = `TMR2_DIV_BAUD;
    end else if (tick_speed_select_q) begin
      div_sel = `TMR2_DIV_FAST;
    end else begin
      div_sel = `TMR2_DIV_SLOW;
    end
  end

  // Prescaler runs only while the timer runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_q <= 4'h0;
    end else if (!ctrl_q[`TMR2_BIT_RUN] || presc_tick) begin
      presc_q <= 4'h0;
    end else begin
      presc_q <= presc_q + 4'h1;
    end
  end
  assign presc_tick = ctrl_q[`TMR2_BIT_RUN] && (presc_q == div_sel - 4'h1);

  // Counter source: prescaled clock, or pin edges outside baud mode
  always_comb begin
    if (!ctrl_q[`TMR2_BIT_RUN]) begin
      inc = 1'b0;
    end else if (baud_mode || !ctrl_q[`TMR2_BIT_SRC_SEL]) begin
      inc = presc_tick;
    end else begin
      inc = cnt_fall;
    end
  end

  assign ovf = inc && (count_q == 16'hFFFF);
  assign reload_val = {cap_hi_q, cap_lo_q};
  assign trg_event = ctrl_q[`TMR2_BIT_TRIG_EN] && trg_fall;
  assign capture = trg_event && (mode == TMR2_CAPTURE);
  // Overflow reloads in reload and baud modes; a trigger edge reloads in reload mode only,
  // but only while running, so a halted timer keeps its count
  assign reload = (ovf && (mode != TMR2_CAPTURE))
    || (trg_event && ctrl_q[`TMR2_BIT_RUN] && (mode == TMR2_RELOAD));

  // ****************************************
  // Counter
  // ****************************************
  // Software byte writes win over counting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= {`TMR2_RST_BYTE, `TMR2_RST_BYTE};
    end else if (wr_cnt_lo) begin
      count_q[7:0] <= wb_dat_i[7:0];
    end else if (wr_cnt_hi) begin
      count_q[15:8] <= wb_dat_i[7:0];
    end else if (reload) begin
      count_q <= reload_val;
    end else if (inc) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Capture/reload bytes; a capture wins over a software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_lo_q <= `TMR2_RST_BYTE;
      cap_hi_q <= `TMR2_RST_BYTE;
    end else if (capture) begin
      cap_lo_q <= count_q[7:0];
      cap_hi_q <= count_q[15:8];
    end else begin
      if (wr_cap_lo) begin
        cap_lo_q <= wb_dat_i[7:0];
      end
      if (wr_cap_hi) begin
        cap_hi_q <= wb_dat_i[7:0];
      end
    end
  end

  // ****************************************
  // Control register and clock control
  // ****************************************
  // Hardware flag set wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `TMR2_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wb_dat_i[7:0];
      end
      if (ovf && !baud_mode) begin
        ctrl_q[`TMR2_BIT_OVF_FLAG] <= 1'b1;
      end
      if (trg_event) begin
        ctrl_q[`TMR2_BIT_TRIG_FLAG] <= 1'b1;
      end
    end
  end

  // Tick speed select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_speed_select_q <= 1'b0;
    end else if (wr_en && (idx == `TMR2_IDX_CLK_CTRL)) begin
      tick_speed_select_q <= wb_dat_i[`TMR2_BIT_TICK_SPEED];
    end
  end

  // ****************************************
  // Serial timebase
  // ****************************************
  assign rx_baud_tick_o = ctrl_q[`TMR2_BIT_RX_SEL] ? ovf : timer1_overflow_i;
  assign tx_baud_tick_o = ctrl_q[`TMR2_BIT_TX_SEL] ? ovf : timer1_overflow_i;

  // ****************************************
  // Interrupts
  // ****************************************
  // Sticky status; set wins over the write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= 2'h0;
    end else begin
      if (wr_en && (idx == `TMR2_IDX_IRQ_CLEAR)) begin
        irq_stat_q <= irq_stat_q & ~wb_dat_i[1:0];
      end
      if (ovf && !baud_mode) begin
        irq_stat_q[`TMR2_IRQ_OVF] <= 1'b1;
      end
      if (trg_event) begin
        irq_stat_q[`TMR2_IRQ_TRIG] <= 1'b1;
      end
    end
  end

  // Enable register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_q <= 2'h0;
    end else if (wr_en && (idx == `TMR2_IDX_IRQ_ENABLE)) begin
      irq_en_q <= wb_dat_i[1:0];
    end
  end
  assign irq_o = |(irq_stat_q & irq_en_q);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !ack_q;
  endsequence
  sequence s_baud_tick;
    baud_mode && ctrl_q[`TMR2_BIT_RUN] && inc && !reload && !wr_cnt_lo && !wr_cnt_hi && !wr_ctrl;
  endsequence

  a_bus_ack_once: assert property (s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
  a_baud_every_two: assert property (s_baud_tick ##1 !wr_ctrl |-> !inc ##1 inc)
    else $error("baud tick not every two clocks");
  a_halt_keeps_count: assert property ((!ctrl_q[`TMR2_BIT_RUN] && !wr_cnt_lo && !wr_cnt_hi)
    |=> $stable(count_q))
    else $error("halted counter moved");
  a_edge_counts_once: assert property ((ctrl_q[`TMR2_BIT_RUN] && !baud_mode && ctrl_q[`TMR2_BIT_SRC_SEL]
    && cnt_fall && !ovf && !reload && !wr_cnt_lo && !wr_cnt_hi) |=> (count_q == $past(count_q) + 16'h0001)
    ##1 !cnt_fall)
    else $error("pin edge not counted once");
  a_ovf_reloads: assert property ((ovf && mode != TMR2_CAPTURE && !wr_cnt_lo && !wr_cnt_hi)
    |=> count_q == $past(reload_val))
    else $error("overflow did not reload");
  a_ovf_sets_flag: assert property ((ovf && !baud_mode) |=> ctrl_q[`TMR2_BIT_OVF_FLAG])
    else $error("overflow flag not set");
  a_capture_bytes: assert property (capture |=> {cap_hi_q, cap_lo_q} == $past(count_q))
    else $error("capture bytes wrong");
  a_trig_disabled: assert property ((!ctrl_q[`TMR2_BIT_TRIG_EN] && !wr_cap_lo && !wr_cap_hi)
    |=> $stable(cap_lo_q) && $stable(cap_hi_q))
    else $error("capture without trigger enable");
  a_tx_source: assert property (tx_baud_tick_o == (ctrl_q[`TMR2_BIT_TX_SEL] ? ovf : timer1_overflow_i))
    else $error("transmit timebase wrong");
  a_rx_source: assert property (ctrl_q[`TMR2_BIT_RX_SEL] |-> (rx_baud_tick_o == ovf))
    else $error("receive timebase wrong");
  a_irq_level: assert property (irq_o == |(irq_stat_q & irq_en_q))
    else $error("interrupt level wrong");

endmodule : tmr2_timer
`default_nettype wire

// ### hdl/tmr2_regs.svh
/*
 * Register indices, field positions, reset values and tick divides of the
 * capture/reload timer. Assumes it is included by bare name.
 */
`ifndef TMR2_REGS_SVH
`define TMR2_REGS_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define TMR2_IDX_CONTROL 8'hC8
`define TMR2_IDX_CAP_LO 8'hCA
`define TMR2_IDX_CAP_HI 8'hCB
`define TMR2_IDX_CNT_LO 8'hCC
`define TMR2_IDX_CNT_HI 8'hCD
`define TMR2_IDX_CLK_CTRL 8'hE0
`define TMR2_IDX_IRQ_STATUS 8'hE1
`define TMR2_IDX_IRQ_CLEAR 8'hE2
`define TMR2_IDX_IRQ_ENABLE 8'hE3

// ****************************************
// Control, clock control and interrupt register fields
// ****************************************
`define TMR2_BIT_OVF_FLAG 7
`define TMR2_BIT_TRIG_FLAG 6
`define TMR2_BIT_RX_SEL 5
`define TMR2_BIT_TX_SEL 4
`define TMR2_BIT_TRIG_EN 3
`define TMR2_BIT_RUN 2
`define TMR2_BIT_SRC_SEL 1
`define TMR2_BIT_CAP_SEL 0
`define TMR2_BIT_TICK_SPEED 5
`define TMR2_IRQ_OVF 0
`define TMR2_IRQ_TRIG 1

// ****************************************
// Reset values and tick divides
// ****************************************
`define TMR2_RST_BYTE 8'h00
`define TMR2_DIV_BAUD 4'h2
`define TMR2_DIV_SLOW 4'hC
`define TMR2_DIV_FAST 4'h4

`endif

// ### hdl/tmr2_pkg.sv
/*
 * Types shared by the capture/reload timer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tmr2_pkg;

  // Operating mode, Gray coded along reload -> capture -> baud
  typedef enum logic [1:0] {
    TMR2_RELOAD = 2'h0,
    TMR2_CAPTURE = 2'h1,
    TMR2_BAUD = 2'h3
  } tmr2_mode_type;

endpackage : tmr2_pkg

// ### verif/tmr2_pin_model.sv
/*
 * Model of the pins around the timer: count pin, trigger pin and the
 * other timer's overflow pulse. Assumes the bench clock on clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
module tmr2_pin_model (
  // Clock
  input wire logic clk_i,
  // Pins toward the timer
  output logic count_pin_o,
  output logic trig_pin_o,
  output logic t1_ovf_o
);
  int div_q = 0; // Divider for the other timer's overflow
  // Pins idle high, no overflow
  initial begin
    count_pin_o = 1'b1;
    trig_pin_o = 1'b1;
    t1_ovf_o = 1'b0;
  end
  // Other timer overflows once every 7 clocks
  always @(posedge clk_i) begin
    div_q <= (div_q == 6) ? 0 : div_q + 1;
    t1_ovf_o <= (div_q == 6);
  end
  // Falling edges on one pin, each level held 5 clocks so none is lost
  task automatic pulse(input bit trig, input int n);
    repeat (n) begin
      repeat (5) @(posedge clk_i);
      if (trig) trig_pin_o <= 1'b0;
      else count_pin_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      if (trig) trig_pin_o <= 1'b1;
      else count_pin_o <= 1'b1;
    end
    repeat (8) @(posedge clk_i);
  endtask : pulse
endmodule : tmr2_pin_model
`default_nettype wire

// ### verif/tmr2_timer_tb_top.sv
/*
 * Self-checking bench of the capture/reload timer over Wishbone.
 * Assumes the timer, its register header and the pin model.
 */
`timescale 1ns/1ns
`default_nettype none
`include "tmr2_regs.svh"
module tmr2_timer_tb_top;
  import tmr2_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, irq, rx, tx, cpin, tpin, t1;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o;
  logic [7:0] rd, c0, c1;
  int bad_count = 0;
  int cmp_count = 0;
  // Rows: index, written byte, expected read back
  localparam logic [23:0] ROWS [7] = '{24'hCAA5A5, 24'hCB5A5A, 24'hCC3C3C, 24'hCDC3C3,
    24'hE30303, 24'h10FF00, 24'hE1FF00};
  localparam logic [7:0] REGS [5] = '{8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC8};
  tmr2_timer i_tmr2_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .count_input_pin_i(cpin), .ext_trigger_pin_i(tpin),
    .timer1_overflow_i(t1), .rx_baud_tick_o(rx), .tx_baud_tick_o(tx), .irq_o(irq));
  tmr2_pin_model i_tmr2_pin_model (.clk_i(clk_i), .count_pin_o(cpin), .trig_pin_o(tpin),
    .t1_ovf_o(t1));
  // ****************************************
  // Checks and bus cycles
  // ****************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Classic single cycle; held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, wd};
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  // Clear counter, run for k clocks, halt, read low byte
  task automatic meas(input logic [7:0] ctl, input int k, output logic [7:0] c);
    bus(1, 8'hCC, 8'h00);
    bus(1, 8'hCD, 8'h00);
    bus(1, 8'hC8, ctl);
    repeat (k) @(posedge clk_i);
    bus(1, 8'hC8, ctl & 8'hFB);
    bus(0, 8'hCC, 8'h00);
    c = rd;
  endtask : meas
  // Interrupt level, looked at mid-cycle
  task automatic irqchk(input logic e);
    @(negedge clk_i);
    chk({7'h0, irq}, {7'h0, e});
    @(posedge clk_i);
  endtask : irqchk
  // Baud ticks over 320 clocks; the other output must mirror the other timer
  task automatic ticks(input bit rxsel);
    int n, b;
    n = 0;
    b = 0;
    repeat (320) begin
      @(negedge clk_i);
      if ((rxsel ? rx : tx) === 1'b1) n++;
      if ((rxsel ? tx : rx) !== t1) b++;
    end
    @(posedge clk_i);
    chk(n[7:0], 8'd10);
    chk(b[7:0], 8'd0);
  endtask : ticks
  // ****************************************
  // Clock, watchdog and sequence
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #(100 * 40000);
    bad_count++;
    end_of_test();
  end
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we} = 3'b000;
    adr = 10'h0;
    sel = 4'hF;
    dat = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Row loop: write then read back
    for (int i = 0; i < 7; i++) begin
      bus(1, ROWS[i][23:16], ROWS[i][15:8]);
      bus(0, ROWS[i][23:16], 8'h00);
      chk(rd, ROWS[i][7:0]);
    end
    // Second reset clears the capture, count and control bytes
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (REGS[i]) begin
      bus(0, REGS[i], 8'h00);
      chk(rd, `TMR2_RST_BYTE);
    end
    // Tick rates from the prescaler
    meas(8'h04, 60, c0);
    meas(8'h04, 180, c1);
    chk(c1 - c0, 8'd10);
    bus(1, 8'hE0, 8'h20);
    meas(8'h04, 60, c0);
    meas(8'h04, 180, c1);
    chk(c1 - c0, 8'd30);
    bus(1, 8'hE0, 8'h00);
    meas(8'h16, 60, c0);
    meas(8'h16, 180, c1);
    chk(c1 - c0, 8'd60);
    repeat (30) @(posedge clk_i);
    bus(0, 8'hCC, 8'h00);
    chk(rd, c1);
    // Pin counting
    bus(1, 8'hCC, 8'h00);
    bus(1, 8'hC8, 8'h06);
    i_tmr2_pin_model.pulse(0, 5);
    bus(0, 8'hCC, 8'h00);
    chk(rd, 8'h05);
    // Overflow reloads and raises the flag and interrupt
    bus(1, 8'hCA, 8'h34);
    bus(1, 8'hCB, 8'h12);
    bus(1, 8'hCC, 8'hFF);
    bus(1, 8'hCD, 8'hFF);
    i_tmr2_pin_model.pulse(0, 1);
    bus(0, 8'hCC, 8'h00);
    chk(rd, 8'h34);
    bus(0, 8'hCD, 8'h00);
    chk(rd, 8'h12);
    bus(0, 8'hC8, 8'h00);
    chk(rd, 8'h86);
    bus(1, 8'hE3, 8'h01);
    irqchk(1'b1);
    bus(1, 8'hE3, 8'h00);
    irqchk(1'b0);
    bus(1, 8'hE2, 8'h01);
    bus(0, 8'hE1, 8'h00);
    chk(rd, 8'h00);
    // Capture on a trigger edge
    bus(1, 8'hCD, 8'h5A);
    bus(1, 8'hCC, 8'h00);
    bus(1, 8'hC8, 8'h0F);
    i_tmr2_pin_model.pulse(0, 3);
    i_tmr2_pin_model.pulse(1, 1);
    bus(0, 8'hCA, 8'h00);
    chk(rd, 8'h03);
    bus(0, 8'hCB, 8'h00);
    chk(rd, 8'h5A);
    bus(0, 8'hC8, 8'h00);
    chk(rd, 8'h4F);
    bus(0, 8'hE1, 8'h00);
    chk(rd, 8'h02);
    // Trigger in reload mode reloads only while running
    bus(1, 8'hC8, 8'h0A);
    bus(1, 8'hCC, 8'h77);
    i_tmr2_pin_model.pulse(1, 1);
    bus(0, 8'hCC, 8'h00);
    chk(rd, 8'h77);
    bus(1, 8'hC8, 8'h0E);
    i_tmr2_pin_model.pulse(1, 1);
    bus(0, 8'hCC, 8'h00);
    chk(rd, 8'h03);
    // Halt first so the prescaler starts the baud run from zero
    bus(1, 8'hC8, 8'h00);
    // Baud timebase, capture select set but ignored
    bus(1, 8'hCA, 8'hF0);
    bus(1, 8'hCB, 8'hFF);
    bus(1, 8'hCC, 8'hF0);
    bus(1, 8'hCD, 8'hFF);
    bus(1, 8'hC8, 8'h15);
    ticks(1'b0);
    bus(1, 8'hC8, 8'h25);
    ticks(1'b1);
    bus(0, 8'hC8, 8'h00);
    chk(rd, 8'h25);
    end_of_test();
  end
endmodule : tmr2_timer_tb_top
`default_nettype wire
